// ===== src/oms_regs.sv
module oms_regs #(
	parameter int SLEEP_IDLE_CYC = oms_pkg::SLEEP_IDLE_CYC
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic sclk_in,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe_out,
	input wire logic frame_valid_in,
	input wire logic [7:0] frame_dx_in,
	input wire logic [7:0] frame_dy_in,
	input wire logic [7:0] frame_quality_in,
	output logic power_down_out,
	output logic sleep_out,
	output logic chip_reset_out
);

	// Chip reset, pulled by the soft reset flop
	logic soft_rst_r;
	logic sys_rst_n;

	// Link side
	logic [3:0] bit_cnt_r;
	logic [6:0] shift_r;
	logic is_read_r;
	logic [6:0] link_addr_r;
	logic [7:0] link_wdata_r;
	logic wr_tog_r;
	logic rd_tog_r;
	logic [6:0] out_shift_r;
	logic sdio_out_r;
	logic sdio_oe_r;

	// System side
	logic wr_tog_s;
	logic rd_tog_s;
	logic wr_tog_d_r;
	logic rd_tog_d_r;
	logic wr_pulse;
	logic rd_pulse;
	logic pwr_down_r;
	logic sleep_dis_r;
	logic [7:0] acc_x_r;
	logic [7:0] acc_y_r;
	logic [7:0] frz_x_r;
	logic [7:0] frz_y_r;
	logic frz_x_vld_r;
	logic frz_y_vld_r;
	logic motion_r;
	logic ovf_x_r;
	logic ovf_y_r;
	logic [7:0] quality_r;
	logic [oms_pkg::IDLE_CNT_W-1:0] idle_cnt_r;
	logic asleep_r;
	logic [7:0] rd_data_r;
	logic [7:0] rd_data_nxt;
	logic rd_status;
	logic rd_x;
	logic rd_y;
	logic clr_acc_x;
	logic clr_acc_y;
	logic sample;
	logic moved;
	logic [8:0] sum_x;
	logic [8:0] sum_y;
	logic ovf_x_evt;
	logic ovf_y_evt;
	logic [7:0] acc_x_nxt;
	logic [7:0] acc_y_nxt;

	assign sys_rst_n = rst_n_in & ~soft_rst_r;

	// ---------------- Link clock domain ----------------

	// Bit counter across one 16-bit frame
	always_ff @(posedge sclk_in or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			bit_cnt_r <= oms_pkg::FRM_START;
		end else begin
			bit_cnt_r <= bit_cnt_r + 4'h1;
		end
	end

	// Input shift register, sampled on rising edge
	always_ff @(posedge sclk_in or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			shift_r <= 7'h00;
		end else begin
			shift_r <= {shift_r[5:0], sdio_in};
		end
	end

	// Address phase capture and read request
	always_ff @(posedge sclk_in or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			link_addr_r <= 7'h00;
			is_read_r <= 1'b0;
			rd_tog_r <= 1'b0;
		end else if (bit_cnt_r == oms_pkg::FRM_ADDR_LAST) begin
			link_addr_r <= {shift_r[5:0], sdio_in};
			is_read_r <= ~shift_r[oms_pkg::FRM_RW_POS];
			if (!shift_r[oms_pkg::FRM_RW_POS]) begin
				rd_tog_r <= ~rd_tog_r;
			end
		end
	end

	// Data phase capture and write request
	always_ff @(posedge sclk_in or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			link_wdata_r <= 8'h00;
			wr_tog_r <= 1'b0;
		end else if (bit_cnt_r == oms_pkg::FRM_DATA_LAST && !is_read_r) begin
			link_wdata_r <= {shift_r, sdio_in};
			wr_tog_r <= ~wr_tog_r;
		end
	end

	// Read data driven on falling edge
	always_ff @(negedge sclk_in or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			sdio_out_r <= 1'b0;
			sdio_oe_r <= 1'b0;
			out_shift_r <= 7'h00;
		end else if (bit_cnt_r == oms_pkg::FRM_DATA_FIRST && is_read_r) begin
			sdio_oe_r <= 1'b1;
			sdio_out_r <= rd_data_r[7];
			out_shift_r <= rd_data_r[6:0];
		end else if (bit_cnt_r == oms_pkg::FRM_START) begin
			sdio_oe_r <= 1'b0;
			sdio_out_r <= 1'b0;
		end else if (sdio_oe_r) begin
			sdio_out_r <= out_shift_r[6];
			out_shift_r <= {out_shift_r[5:0], 1'b0};
		end
	end

	assign sdio_out = sdio_out_r;
	assign sdio_oe_out = sdio_oe_r;

	// ---------------- System clock domain ----------------

	oms_sync2 u_wr_sync (
		.clk_in(clk_in),
		.rst_n_in(sys_rst_n),
		.d_in(wr_tog_r),
		.q_out(wr_tog_s)
	);

	oms_sync2 u_rd_sync (
		.clk_in(clk_in),
		.rst_n_in(sys_rst_n),
		.d_in(rd_tog_r),
		.q_out(rd_tog_s)
	);

	// Toggle edge detection
	always_ff @(posedge clk_in or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			wr_tog_d_r <= 1'b0;
			rd_tog_d_r <= 1'b0;
		end else begin
			wr_tog_d_r <= wr_tog_s;
			rd_tog_d_r <= rd_tog_s;
		end
	end

	assign wr_pulse = wr_tog_s ^ wr_tog_d_r;
	assign rd_pulse = rd_tog_s ^ rd_tog_d_r;

	// Soft reset pulse, held in reset by the pin reset only
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= wr_pulse && link_addr_r == oms_pkg::ADDR_MODE
				&& link_wdata_r[oms_pkg::MODE_SOFT_RST_BIT];
		end
	end

	// Mode register; other addresses ignore writes
	always_ff @(posedge clk_in or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			pwr_down_r <= oms_pkg::MODE_PWR_DOWN_RST;
			sleep_dis_r <= oms_pkg::MODE_SLEEP_DIS_RST;
		end else if (wr_pulse && link_addr_r == oms_pkg::ADDR_MODE) begin
			pwr_down_r <= link_wdata_r[oms_pkg::MODE_PWR_DOWN_BIT];
			sleep_dis_r <= link_wdata_r[oms_pkg::MODE_SLEEP_DIS_BIT];
		end
	end

	// Read decode
	assign rd_status = rd_pulse && link_addr_r == oms_pkg::ADDR_STATUS;
	assign rd_x = rd_pulse && link_addr_r == oms_pkg::ADDR_DELTA_X;
	assign rd_y = rd_pulse && link_addr_r == oms_pkg::ADDR_DELTA_Y;
	assign clr_acc_x = rd_status || (rd_x && !frz_x_vld_r);
	assign clr_acc_y = rd_status || (rd_y && !frz_y_vld_r);

	// Saturating accumulation; a sample in a clearing cycle starts afresh
	assign sample = frame_valid_in && !pwr_down_r;
	assign moved = sample && (frame_dx_in != 8'h00 || frame_dy_in != 8'h00);
	assign sum_x = {acc_x_nxt_base(clr_acc_x, acc_x_r)} + {frame_dx_in[7], frame_dx_in};
	assign sum_y = {acc_x_nxt_base(clr_acc_y, acc_y_r)} + {frame_dy_in[7], frame_dy_in};
	assign ovf_x_evt = sample && (sum_x[8] != sum_x[7]);
	assign ovf_y_evt = sample && (sum_y[8] != sum_y[7]);

	function automatic logic [8:0] acc_x_nxt_base(input logic clr, input logic [7:0] acc);
		acc_x_nxt_base = clr ? 9'h000 : {acc[7], acc};
	endfunction

	function automatic logic [7:0] sat8(input logic [8:0] s);
		if (s[8] != s[7]) begin
			sat8 = s[8] ? oms_pkg::DELTA_MIN : oms_pkg::DELTA_MAX;
		end else begin
			sat8 = s[7:0];
		end
	endfunction

	always_comb begin
		if (sample) begin
			acc_x_nxt = sat8(sum_x);
			acc_y_nxt = sat8(sum_y);
		end else begin
			acc_x_nxt = clr_acc_x ? 8'h00 : acc_x_r;
			acc_y_nxt = clr_acc_y ? 8'h00 : acc_y_r;
		end
	end

	always_ff @(posedge clk_in or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			acc_x_r <= 8'h00;
			acc_y_r <= 8'h00;
		end else begin
			acc_x_r <= acc_x_nxt;
			acc_y_r <= acc_y_nxt;
		end
	end

	// Frozen copies taken on status read
	always_ff @(posedge clk_in or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			frz_x_r <= 8'h00;
			frz_y_r <= 8'h00;
			frz_x_vld_r <= 1'b0;
			frz_y_vld_r <= 1'b0;
		end else if (rd_status) begin
			frz_x_r <= acc_x_r;
			frz_y_r <= acc_y_r;
			frz_x_vld_r <= 1'b1;
			frz_y_vld_r <= 1'b1;
		end else begin
			if (rd_x) begin
				frz_x_vld_r <= 1'b0;
			end
			if (rd_y) begin
				frz_y_vld_r <= 1'b0;
			end
		end
	end

	// Status flags; a new event wins over the clear
	always_ff @(posedge clk_in or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			motion_r <= 1'b0;
			ovf_x_r <= 1'b0;
			ovf_y_r <= 1'b0;
		end else begin
			motion_r <= moved || (motion_r && !rd_status);
			ovf_x_r <= ovf_x_evt || (ovf_x_r && !rd_status);
			ovf_y_r <= ovf_y_evt || (ovf_y_r && !rd_status);
		end
	end

	// Frame quality latch
	always_ff @(posedge clk_in or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			quality_r <= 8'h00;
		end else if (sample) begin
			quality_r <= frame_quality_in;
		end
	end

	// Idle timer and automatic sleep
	always_ff @(posedge clk_in or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			idle_cnt_r <= '0;
			asleep_r <= 1'b0;
		end else if (moved || sleep_dis_r) begin
			idle_cnt_r <= '0;
			asleep_r <= 1'b0;
		end else if (idle_cnt_r == oms_pkg::IDLE_CNT_W'(SLEEP_IDLE_CYC - 1)) begin
			asleep_r <= 1'b1;
		end else begin
			idle_cnt_r <= idle_cnt_r + 1'b1;
		end
	end

	// Read data mux
	always_comb begin
		rd_data_nxt = 8'h00;
		if (link_addr_r == oms_pkg::ADDR_MODE) begin
			rd_data_nxt[oms_pkg::MODE_PWR_DOWN_BIT] = pwr_down_r;
			rd_data_nxt[oms_pkg::MODE_SLEEP_DIS_BIT] = sleep_dis_r;
		end else if (link_addr_r == oms_pkg::ADDR_IDENT) begin
			rd_data_nxt[7:5] = oms_pkg::IDENT_PART_CODE;
			rd_data_nxt[oms_pkg::IDENT_OPSTATE_BIT] = ~asleep_r;
		end else if (link_addr_r == oms_pkg::ADDR_DELTA_Y) begin
			rd_data_nxt = frz_y_vld_r ? frz_y_r : acc_y_r;
		end else if (link_addr_r == oms_pkg::ADDR_DELTA_X) begin
			rd_data_nxt = frz_x_vld_r ? frz_x_r : acc_x_r;
		end else if (link_addr_r == oms_pkg::ADDR_QUALITY) begin
			rd_data_nxt = quality_r;
		end else if (link_addr_r == oms_pkg::ADDR_PART_HI) begin
			rd_data_nxt = oms_pkg::PART_CODE_HI;
		end else if (link_addr_r == oms_pkg::ADDR_PART_LO) begin
			rd_data_nxt = {oms_pkg::PART_CODE_LO_NIB, oms_pkg::PART_CODE_LO_RSVD};
		end else if (link_addr_r == oms_pkg::ADDR_STATUS) begin
			rd_data_nxt[oms_pkg::STAT_MOTION_BIT] = motion_r;
			rd_data_nxt[oms_pkg::STAT_Y_OVF_BIT] = ovf_y_r;
			rd_data_nxt[oms_pkg::STAT_X_OVF_BIT] = ovf_x_r;
			rd_data_nxt[oms_pkg::STAT_RES_BIT] = oms_pkg::STAT_RES_VAL;
		end
	end

	// Read data held stable for the link
	always_ff @(posedge clk_in or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			rd_data_r <= 8'h00;
		end else if (rd_pulse) begin
			rd_data_r <= rd_data_nxt;
		end
	end

	// Outputs
	always_ff @(posedge clk_in or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			power_down_out <= 1'b0;
			sleep_out <= 1'b0;
		end else begin
			power_down_out <= pwr_down_r;
			sleep_out <= asleep_r;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			chip_reset_out <= 1'b0;
		end else begin
			chip_reset_out <= soft_rst_r;
		end
	end

endmodule // oms_regs

// ===== src/oms_pkg.sv
package oms_pkg;

	// Register addresses
	localparam logic [6:0] ADDR_MODE = 7'h00;
	localparam logic [6:0] ADDR_IDENT = 7'h01;
	localparam logic [6:0] ADDR_DELTA_Y = 7'h02;
	localparam logic [6:0] ADDR_DELTA_X = 7'h03;
	localparam logic [6:0] ADDR_QUALITY = 7'h04;
	localparam logic [6:0] ADDR_PART_HI = 7'h14;
	localparam logic [6:0] ADDR_PART_LO = 7'h15;
	localparam logic [6:0] ADDR_STATUS = 7'h16;

	// Mode register fields
	localparam int MODE_SOFT_RST_BIT = 7;
	localparam int MODE_PWR_DOWN_BIT = 6;
	localparam int MODE_SLEEP_DIS_BIT = 0;
	localparam logic MODE_PWR_DOWN_RST = 1'b0;
	localparam logic MODE_SLEEP_DIS_RST = 1'b0;

	// Identity register fields
	localparam int IDENT_OPSTATE_BIT = 0;
	// Arbitrary part code value
	localparam logic [2:0] IDENT_PART_CODE = 3'h5;

	// Part code bytes, arbitrary values
	localparam logic [7:0] PART_CODE_HI = 8'hA6;
	localparam logic [3:0] PART_CODE_LO_NIB = 4'h3;
	localparam logic [3:0] PART_CODE_LO_RSVD = 4'h0;

	// Status register fields
	localparam int STAT_MOTION_BIT = 7;
	localparam int STAT_Y_OVF_BIT = 4;
	localparam int STAT_X_OVF_BIT = 3;
	localparam int STAT_RES_BIT = 0;
	localparam logic STAT_RES_VAL = 1'b0;

	// Saturation limits of the deltas
	localparam logic [7:0] DELTA_MAX = 8'h7F;
	localparam logic [7:0] DELTA_MIN = 8'h80;

	// Serial frame layout
	localparam logic [3:0] FRM_ADDR_LAST = 4'h7;
	localparam logic [3:0] FRM_DATA_FIRST = 4'h8;
	localparam logic [3:0] FRM_DATA_LAST = 4'hF;
	localparam logic [3:0] FRM_START = 4'h0;
	localparam int FRM_RW_POS = 6;

	// Timing
	localparam int CLK_HZ = 10000000;
	localparam int SLEEP_IDLE_MS = 1000;
	localparam int SLEEP_IDLE_CYC = SLEEP_IDLE_MS * (CLK_HZ / 1000);
	localparam int IDLE_CNT_W = 24;

endpackage

// ===== src/oms_sync2.sv
module oms_sync2 (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic d_in,
	output logic q_out
);

	logic meta_r;
	logic sync_r;

	// Two flip-flop level synchroniser
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= d_in;
			sync_r <= meta_r;
		end
	end

	assign q_out = sync_r;

endmodule // oms_sync2

// ===== verif/oms_regs_asserts.sv
module oms_regs_asserts #(
	parameter int SLEEP_IDLE_CYC = 20
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic sclk_in,
	input wire logic sdio_in,
	input wire logic sdio_out,
	input wire logic sdio_oe_out,
	input wire logic frame_valid_in,
	input wire logic [7:0] frame_dx_in,
	input wire logic [7:0] frame_dy_in,
	input wire logic [7:0] frame_quality_in,
	input wire logic power_down_out,
	input wire logic sleep_out,
	input wire logic chip_reset_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] lnk_r;
	logic [23:0] idle_r;
	logic mot;
	assign mot = frame_valid_in && !power_down_out && (frame_dx_in != 8'h00
		|| frame_dy_in != 8'h00);
	// Cycles since link clock was last low
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lnk_r <= 8'h00;
		end else if (!sclk_in) begin
			lnk_r <= 8'h00;
		end else if (lnk_r != 8'hFF) begin
			lnk_r <= lnk_r + 8'h01;
		end
	end
	// Cycles since last motion, wide enough for the full idle time
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			idle_r <= 24'h000000;
		end else if (mot) begin
			idle_r <= 24'h000000;
		end else if (idle_r != 24'hFFFFFF) begin
			idle_r <= idle_r + 24'h000001;
		end
	end
	sequence s_oe_burst;
		sdio_oe_out [*8] ##1 !sdio_oe_out;
	endsequence
	a_oe_window: assert property (@(negedge sclk_in) disable iff (!rst_n_in)
		$rose(sdio_oe_out) |-> s_oe_burst) else $error("read drive window wrong");
	a_sleep_idle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(sleep_out) |-> idle_r >= SLEEP_IDLE_CYC - 1) else $error("slept too early");
	a_wake_motion: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		mot |-> ##[1:4] !sleep_out) else $error("no wake on motion");
	a_wake_cause: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$fell(sleep_out) |-> idle_r <= 4 || lnk_r <= 10) else $error("wake without cause");
	a_pd_by_link: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$changed(power_down_out) |-> lnk_r <= 10) else $error("power-down moved alone");
	a_crst_by_link: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		chip_reset_out |-> lnk_r <= 10) else $error("chip reset without write");
	a_crst_single: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		chip_reset_out |=> !chip_reset_out) else $error("chip reset too long");
	a_crst_pd_clr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		chip_reset_out |=> !power_down_out) else $error("power-down kept over reset");
endmodule // oms_regs_asserts

bind oms_regs oms_regs_asserts #(.SLEEP_IDLE_CYC(SLEEP_IDLE_CYC)) u_chk (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk_in), .sdio_in(sdio_in),
	.sdio_out(sdio_out), .sdio_oe_out(sdio_oe_out), .frame_valid_in(frame_valid_in),
	.frame_dx_in(frame_dx_in), .frame_dy_in(frame_dy_in),
	.frame_quality_in(frame_quality_in), .power_down_out(power_down_out),
	.sleep_out(sleep_out), .chip_reset_out(chip_reset_out));

// ===== verif/oms_ctl_model.sv
module oms_ctl_model (
	output logic sclk_out,
	output logic sdio_drv_out,
	input wire logic sdio_wire_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		sclk_out = 1'b1;
		sdio_drv_out = 1'b0;
	end
	task automatic tick(input logic b);
		sclk_out = 1'b0;
		sdio_drv_out = b;
		#62.5;
		sclk_out = 1'b1;
		#62.5;
	endtask
	// Released line toggles so a stale level never reads back
	task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] r);
		r = 8'h00;
		// Offset keeps link edges off the system clock edges
		#13;
		tick(w);
		for (int i = 6; i >= 0; i--) begin
			tick(a[i]);
		end
		if (!w) begin
			sdio_drv_out = ~sdio_drv_out;
			#1500;
		end
		for (int i = 7; i >= 0; i--) begin
			if (w) begin
				tick(d[i]);
			end else begin
				tick(~sdio_drv_out);
				r[i] = sdio_wire_in;
			end
		end
		sdio_drv_out = ~sdio_drv_out;
		#1500;
	endtask
endmodule // oms_ctl_model

// ===== verif/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SLP = 200;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic fv = 1'b0;
	logic sclk, drv, wl, sdo, soe, pd, slp, crst;
	logic [7:0] dx = 8'h00;
	logic [7:0] dy = 8'h00;
	logic [7:0] q = 8'h00;
	logic [7:0] v;
	logic [7:0] n_crst = 8'h00;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	always #50 clk_in = ~clk_in;
	assign wl = soe ? sdo : drv;
	oms_ctl_model ctl (.sclk_out(sclk), .sdio_drv_out(drv), .sdio_wire_in(wl));
	oms_regs #(.SLEEP_IDLE_CYC(SLP)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.sclk_in(sclk), .sdio_in(wl), .sdio_out(sdo), .sdio_oe_out(soe),
		.frame_valid_in(fv), .frame_dx_in(dx), .frame_dy_in(dy), .frame_quality_in(q),
		.power_down_out(pd), .sleep_out(slp), .chip_reset_out(crst));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
		num_checks++;
		if (s !== e) begin
			n_fail++;
			$display("unexpected %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic s);
		chk8(nm, {7'h00, e}, {7'h00, s});
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e, input string nm);
		@(negedge clk_in);
		ctl.xfer(1'b0, a, 8'h00, v);
		chk8(nm, e, v);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk_in);
		ctl.xfer(1'b1, a, d, v);
	endtask
	task automatic frm(input logic [7:0] x, input logic [7:0] y, input logic [7:0] qq);
		@(negedge clk_in);
		fv = 1'b1;
		dx = x;
		dy = y;
		q = qq;
		@(negedge clk_in);
		fv = 1'b0;
	endtask
	always @(negedge clk_in) begin
		if (crst === 1'b1) begin
			n_crst = n_crst + 8'h01;
		end
	end
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			end_sim();
		end
	end
	initial begin
		repeat (10) @(negedge clk_in);
		rst_n_in = 1'b1;
		repeat (3) @(negedge clk_in);
		rd(oms_pkg::ADDR_MODE, 8'h00, "mode");
		wr(oms_pkg::ADDR_MODE, 8'h01);
		rd(oms_pkg::ADDR_IDENT, {oms_pkg::IDENT_PART_CODE, 5'h01}, "ident");
		rd(oms_pkg::ADDR_PART_HI, oms_pkg::PART_CODE_HI, "part_hi");
		@(negedge clk_in);
		ctl.xfer(1'b0, oms_pkg::ADDR_PART_LO, 8'h00, v);
		chk8("part_lo", {oms_pkg::PART_CODE_LO_NIB, 4'h0}, v & 8'hF0);
		wr(oms_pkg::ADDR_PART_HI, 8'h55);
		rd(oms_pkg::ADDR_PART_HI, oms_pkg::PART_CODE_HI, "part_hi_wr");
		rd(7'h05, 8'h00, "unmapped");
		$display("test ids done");
		wr(oms_pkg::ADDR_MODE, 8'h41);
		chk1("pd_on", 1'b1, pd);
		rd(oms_pkg::ADDR_MODE, 8'h41, "mode_pd");
		wr(oms_pkg::ADDR_MODE, 8'h01);
		chk1("pd_off", 1'b0, pd);
		$display("test pd done");
		frm(8'h03, 8'hFB, 8'h00);
		frm(8'h03, 8'h00, 8'hFF);
		rd(oms_pkg::ADDR_DELTA_X, 8'h06, "dx");
		rd(oms_pkg::ADDR_DELTA_Y, 8'hFB, "dy");
		rd(oms_pkg::ADDR_DELTA_X, 8'h00, "dx_clr");
		rd(oms_pkg::ADDR_QUALITY, 8'hFF, "qual");
		for (int i = 0; i < 3; i++) begin
			frm(8'h7F, 8'h80, 8'h00);
		end
		rd(oms_pkg::ADDR_STATUS, 8'h98, "status");
		frm(8'h01, 8'h00, 8'h00);
		rd(oms_pkg::ADDR_DELTA_X, 8'h7F, "dx_frozen");
		rd(oms_pkg::ADDR_DELTA_Y, 8'h80, "dy_frozen");
		rd(oms_pkg::ADDR_DELTA_X, 8'h01, "dx_live");
		rd(oms_pkg::ADDR_STATUS, 8'h80, "status_clr");
		rd(oms_pkg::ADDR_QUALITY, 8'h00, "qual0");
		$display("test motion done");
		wr(oms_pkg::ADDR_MODE, 8'h00);
		repeat (SLP + 20) @(negedge clk_in);
		chk1("asleep", 1'b1, slp);
		rd(oms_pkg::ADDR_IDENT, {oms_pkg::IDENT_PART_CODE, 5'h00}, "ident_slp");
		frm(8'h00, 8'h02, 8'h00);
		repeat (5) @(negedge clk_in);
		chk1("awake", 1'b0, slp);
		wr(oms_pkg::ADDR_MODE, 8'h01);
		repeat (SLP + 20) @(negedge clk_in);
		chk1("no_sleep", 1'b0, slp);
		$display("test sleep done");
		wr(oms_pkg::ADDR_MODE, 8'h41);
		wr(oms_pkg::ADDR_MODE, 8'h80);
		chk8("crst_cnt", 8'h01, n_crst);
		chk1("pd_clr", 1'b0, pd);
		rd(oms_pkg::ADDR_MODE, 8'h00, "mode_rst");
		$display("test soft reset done");
		end_sim();
	end
endmodule // tb
